// ===== urx_core.v
// Receive side of an asynchronous serial port with address recognition.
// Assumes one clock, a plain register port and an asynchronous rx line.
// Notes on behaviour
// - With fe_select set, control bit 7 shows the framing error flag.
// - Frame starts on a falling edge, line sampled at sixteen times bit rate.
// - Falling edge resets the sixteenth counter to align bit boundaries.
// - Samples at states seven, eight, nine; majority of three wins.
// - A start bit sampled as one abandons the frame and hunts again.
// - 8-bit mode loads only if done flag clear and no filter or good stop.
// - 8-bit mode: stop bit to ninth flag, data to buffer, done flag set.
// - 9-bit modes receive with the same start and sampling scheme.
// - 9-bit modes load only if done flag clear and no filter or ninth one.
// - Failed 9-bit acceptance drops the frame, done flag stays clear.
// - 9-bit modes: ninth bit to ninth flag, eight data bits to buffer.
// - Multiproc enable has no effect in shift-register mode.
// - With filtering in 9-bit modes, only ninth-one bytes matching given or broadcast set done.
// - Given address is address register with mask zeros as don't care.
// - Broadcast address is address OR mask, zeros are don't care.
// - Reset clears address and mask registers, so every address byte matches.
// - Bad stop sets framing error; only software clears it.
// - Done flag set about halfway through the stop bit.
// - Reception runs only while receive enable is set.
`default_nettype none
`include "urx_consts.vh"
module urx_core #(
    parameter DATA_BITS = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire rxd_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    output wire rx_done_flag_o,
    output wire framing_error_flag_o
);
    // Receive engine states: hunting for a start edge, checking the start
    // bit, shifting data bits (and the ninth bit in the 9-bit modes), and
    // waiting for the centre of the stop bit where the result is judged.
    // Binary codes keep the state register at two flops.
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_STOP = 2'h3;

    // Software-visible registers. The control register keeps mode, enable,
    // filter enable, ninth bit and done flag; bit 7 is shared between mode
    // select bit 0 and the framing error view, chosen by fe_select in the
    // power control register. The framing error flag lives apart so that
    // switching the view never loses it.
    // Only the divisor's low byte is writable; the high byte is held at zero.
    reg [7:0] serial_control_reg;
    reg [7:0] power_control_reg;
    reg [7:0] serial_buffer;
    reg [7:0] slave_address_reg;
    reg [7:0] slave_address_mask_reg;
    reg [15:0] baud_div_reg;
    reg framing_error_flag;
    reg [15:0] div_cnt_reg;
    reg [3:0] phase_reg;
    reg [1:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [8:0] shift_reg;
    reg sync1_reg;
    reg sync2_reg;
    reg line_prev_reg;
    reg sample_done_reg;
    // Decoded control fields and internal strobes; all come from flops on
    // this clock, so no further synchronising is needed past the pin flops.
    // Names follow the control register fields they are cut from.
    wire sampled_bit;
    wire tick;
    wire fe_select;
    wire receive_enable;
    wire multiproc_enable;
    wire rx_done_flag;
    wire mode_select_bit0;
    wire mode_select_bit1;
    wire nine_bit_mode;
    wire async_mode;
    wire fall;
    wire center;
    wire [3:0] last_bit;
    wire addr_hit;
    wire accept;
    wire ctrl_wr;

    // Field taps. Mode bit 0 alone selects the 9-bit framing; any mode other
    // than the shift-register one counts as asynchronous. Mode bit 0 stays
    // in the control register even while bit 7 shows the framing error, so
    // the frame format does not change when the view is switched.
    assign fe_select = power_control_reg[`URX_PWR_FESEL];
    assign receive_enable = serial_control_reg[`URX_CTRL_REN];
    assign multiproc_enable = serial_control_reg[`URX_CTRL_SM2];
    assign rx_done_flag = serial_control_reg[`URX_CTRL_RI];
    assign mode_select_bit0 = serial_control_reg[`URX_CTRL_SM0];
    assign mode_select_bit1 = serial_control_reg[`URX_CTRL_SM1];
    assign nine_bit_mode = mode_select_bit0;
    assign async_mode = mode_select_bit0 | mode_select_bit1;
    assign rx_done_flag_o = rx_done_flag;
    assign framing_error_flag_o = framing_error_flag;
    assign ctrl_wr = wr_i && (addr_i == `URX_OFF_CTRL);

    // Masked compare of the received byte against one pattern
    // Care bits of zero are skipped; with all care bits zero any byte hits,
    // which is why cleared address and mask registers take every address.
    // Shared by the given and the broadcast compare.
    function match_fn;
        input [7:0] data;
        input [7:0] pattern;
        input [7:0] care;
        begin
            match_fn = ((data ^ pattern) & care) == 8'h00;
        end
    endfunction

    assign addr_hit = match_fn(shift_reg[7:0], slave_address_reg & slave_address_mask_reg,
                               slave_address_mask_reg) |
                      match_fn(shift_reg[7:0], slave_address_reg | slave_address_mask_reg,
                               slave_address_reg | slave_address_mask_reg);

    // Acceptance is judged at the stop bit centre. A set done flag always
    // blocks a load, so a slow reader loses later frames rather than having
    // its buffer overwritten. In 8-bit mode the filter looks at the stop bit,
    // in the 9-bit modes at the ninth bit and the address compare.
    // Acceptance for the 8-bit and the 9-bit modes
    assign accept = !rx_done_flag && (!multiproc_enable ||
                    (nine_bit_mode ? (shift_reg[8] && addr_hit) : sampled_bit));

    // Two flops on the pin before any logic reads it
    // The third flop only delays the synchronised level for edge detection.
    // All reset to the idle-high level, so reset never fakes a start edge.
    // Costs two clocks of latency, negligible against a bit time.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            line_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= rxd_i;
            sync2_reg <= sync1_reg;
            line_prev_reg <= sync2_reg;
        end
    end

    assign fall = line_prev_reg & ~sync2_reg;

    // Sixteenth tick from the software divisor; zero means every clock
    // The divider is held at zero while idle, so the first tick after a
    // start edge comes a full divisor period later and phase zero starts
    // right at the edge. Changing the divisor mid-frame skews that frame.
    assign tick = (div_cnt_reg == baud_div_reg);
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            div_cnt_reg <= 16'h0000;
        else if ((state_reg == ST_IDLE) || tick)
            div_cnt_reg <= 16'h0000;
        else
            div_cnt_reg <= div_cnt_reg + 16'h0001;
    end

    // Majority detector; it is cleared while idle so that samples from a
    // rejected start never leak into the next frame. Its decision is read
    // one clock after the third sample tick.
    urx_sampler u_sampler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(state_reg == ST_IDLE),
        .tick_i(tick),
        .phase_i(phase_reg),
        .line_i(sync2_reg),
        .bit_o(sampled_bit)
    );

    // Decision is ready one clock after the third sample tick, at phase ten
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            sample_done_reg <= 1'b0;
        else
            sample_done_reg <= tick && (phase_reg == `URX_S3);
    end
    assign center = sample_done_reg;
    // Data bits plus an optional ninth bit before the stop
    assign last_bit = nine_bit_mode ? DATA_BITS[3:0] : DATA_BITS[3:0] - 4'h1;

    // Receive engine. The phase counter advances on every tick and wraps
    // every sixteen ticks, one bit time. Clearing receive enable drops a
    // frame in flight at once; a half-received byte is never loaded.
    // The bit counter counts data bits plus the ninth bit when present.
    // The limitation: a line held low across the stop centre still ends the
    // frame there and is hunted again only after it has risen.
    // one receive engine for all async modes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            phase_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 9'h000;
        end else begin
            if (tick)
                phase_reg <= phase_reg + 4'h1;
            case (state_reg)
                ST_IDLE: begin
                    if (fall && receive_enable && async_mode) begin
                        phase_reg <= 4'h0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_START;
                    end
                end
                ST_START: begin
                    if (!receive_enable) begin
                        state_reg <= ST_IDLE;
                    end else if (center) begin
                        if (sampled_bit)
                            state_reg <= ST_IDLE;
                        else
                            state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (!receive_enable) begin
                        state_reg <= ST_IDLE;
                    end else if (center) begin
                        // LSB first, shifted down from the top
                        if (nine_bit_mode)
                            shift_reg <= {sampled_bit, shift_reg[8:1]};
                        else
                            shift_reg <= {1'b0, sampled_bit, shift_reg[7:1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == last_bit)
                            state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (center || !receive_enable)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Register writes and receive-side hardware updates; hardware set wins
    // The hardware updates come last in this block, so a software write to
    // the control register in the same cycle as a frame end loses the done
    // flag, ninth bit and framing error fields to the hardware values.
    // Unmapped writes are dropped without side effects.
    // Writing 1 to bit 7 under the error view leaves the flag as it is.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_control_reg <= `URX_CTRL_RST;
            power_control_reg <= 8'h00;
            serial_buffer <= 8'h00;
            slave_address_reg <= `URX_ADDR_RST;
            slave_address_mask_reg <= `URX_MASK_RST;
            baud_div_reg <= `URX_BAUD_RST;
            framing_error_flag <= 1'b0;
        end else begin
            if (wr_i && addr_i == `URX_OFF_PWR)
                power_control_reg <= wdata_i;
            if (wr_i && addr_i == `URX_OFF_ADDR)
                slave_address_reg <= wdata_i;
            if (wr_i && addr_i == `URX_OFF_MASK)
                slave_address_mask_reg <= wdata_i;
            if (wr_i && addr_i == `URX_OFF_BAUD)
                baud_div_reg <= {8'h00, wdata_i};
            if (ctrl_wr) begin
                if (fe_select) begin
                    serial_control_reg[6:0] <= wdata_i[6:0];
                    if (!wdata_i[`URX_CTRL_SM0])
                        framing_error_flag <= 1'b0;
                end else begin
                    serial_control_reg <= wdata_i;
                end
            end
            if ((state_reg == ST_STOP) && center) begin
                if (!sampled_bit)
                    framing_error_flag <= 1'b1;
                if (accept) begin
                    serial_buffer <= shift_reg[7:0];
                    serial_control_reg[`URX_CTRL_RB8] <=
                        nine_bit_mode ? shift_reg[8] : sampled_bit;
                    serial_control_reg[`URX_CTRL_RI] <= 1'b1;
                end
            end
        end
    end

    // Read data, one cycle after the strobe; zero otherwise
    // Reads have no side effects, so the done flag is cleared only by a
    // write; returning zero outside the read slot keeps the bus quiet.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `URX_OFF_CTRL: rdata_o <= fe_select ?
                    {framing_error_flag, serial_control_reg[6:0]} : serial_control_reg;
                `URX_OFF_BUF: rdata_o <= serial_buffer;
                `URX_OFF_ADDR: rdata_o <= slave_address_reg;
                `URX_OFF_MASK: rdata_o <= slave_address_mask_reg;
                `URX_OFF_PWR: rdata_o <= power_control_reg;
                `URX_OFF_BAUD: rdata_o <= baud_div_reg[7:0];
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ===== urx_consts.vh
// Constants for the receive side of the serial port with address recognition.
// Assumes inclusion by bare name from the design files.
`ifndef URX_CONSTS_VH
`define URX_CONSTS_VH
// Register offsets on the plain register port
`define URX_OFF_CTRL 4'h0
`define URX_OFF_BUF 4'h1
`define URX_OFF_ADDR 4'h2
`define URX_OFF_MASK 4'h3
`define URX_OFF_PWR 4'h4
`define URX_OFF_BAUD 4'h5
// Serial control register fields
`define URX_CTRL_RI 0
`define URX_CTRL_RB8 2
`define URX_CTRL_REN 4
`define URX_CTRL_SM2 5
`define URX_CTRL_SM1 6
`define URX_CTRL_SM0 7
// Power control register field
`define URX_PWR_FESEL 6
// Reset values
`define URX_CTRL_RST 8'h00
`define URX_ADDR_RST 8'h00
`define URX_MASK_RST 8'h00
`define URX_BAUD_RST 16'h0000
// Oversampling
`define URX_OVS 16
`define URX_S1 4'h7
`define URX_S2 4'h8
`define URX_S3 4'h9
`endif

// ===== urx_sampler.v
// Majority-of-three bit detector driven by the 16x sample counter.
// Assumes a synchronised line input and a one-cycle tick per sixteenth.
`default_nettype none
`include "urx_consts.vh"
module urx_sampler (
    input wire clk_i,
    input wire rst_i,
    input wire clear_i,
    input wire tick_i,
    input wire [3:0] phase_i,
    input wire line_i,
    output reg bit_o
);
    reg [1:0] smp_reg;

    // Capture the first two samples, decide at the third
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_reg <= 2'h0;
            bit_o <= 1'b1;
        end else if (clear_i) begin
            smp_reg <= 2'h0;
        end else if (tick_i) begin
            if (phase_i == `URX_S1)
                smp_reg[0] <= line_i;
            if (phase_i == `URX_S2)
                smp_reg[1] <= line_i;
            if (phase_i == `URX_S3)
                bit_o <= (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & line_i) |
                         (smp_reg[1] & line_i);
        end
    end
endmodule
`default_nettype wire

// ===== urx_core_sva.sv
// Port-level checker for the receive block with address recognition.
// Assumes the register map of the shared constants header, one clock domain.
`default_nettype none
`include "urx_consts.vh"
module urx_core_sva #(
    parameter DATA_BITS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rxd_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic rx_done_flag_o,
    input wire logic framing_error_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fesel_reg, ren_reg, m0_reg, m1_reg;
    wire ctl_wr = wr_i && addr_i == `URX_OFF_CTRL;
    wire rx_on = ren_reg && (m0_reg || m1_reg);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Shadow of the bits that gate reception; mode bit 0 is hidden under the error view
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {fesel_reg, ren_reg, m0_reg, m1_reg} <= 4'h0;
        end else begin
            if (wr_i && addr_i == `URX_OFF_PWR) fesel_reg <= wdata_i[6];
            if (ctl_wr) ren_reg <= wdata_i[4];
            if (ctl_wr) m1_reg <= wdata_i[6];
            if (ctl_wr && !fesel_reg) m0_reg <= wdata_i[7];
        end
    end
    chk_reset_quiet: assert property ($fell(rst_i) |-> !rx_done_flag_o
        && !framing_error_flag_o && rdata_o == 8'h00) else $error("outputs not clear after reset");
    chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property (rd_i && addr_i > `URX_OFF_BAUD |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_done: assert property (rd_i && addr_i == `URX_OFF_CTRL
        |=> rdata_o[0] == $past(rx_done_flag_o)) else $error("done bit read wrong");
    chk_fe_view: assert property (rd_i && addr_i == `URX_OFF_CTRL && fesel_reg
        |=> rdata_o[7] == $past(framing_error_flag_o)) else $error("error bit view wrong");
    chk_done_sticky: assert property (rx_done_flag_o && !(ctl_wr && !wdata_i[0])
        |=> rx_done_flag_o) else $error("done flag dropped without software");
    chk_fe_sticky: assert property (framing_error_flag_o
        && !(ctl_wr && fesel_reg && !wdata_i[7]) |=> framing_error_flag_o)
        else $error("framing flag dropped without software");
    chk_idle_no_done: assert property (!rx_on && !$past(rx_on)
        |-> !$rose(rx_done_flag_o)) else $error("frame taken while receiver off");
    cover property ($rose(rx_done_flag_o));
    cover property ($rose(framing_error_flag_o));
    cover property (rd_i && addr_i == `URX_OFF_BUF);
endmodule
bind urx_core urx_core_sva #(.DATA_BITS(DATA_BITS)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .rxd_i(rxd_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_done_flag_o(rx_done_flag_o),
    .framing_error_flag_o(framing_error_flag_o));
`default_nettype wire

// ===== urx_node.sv
// Serial node model driving the block's receive line.
// Assumes the bench clock; one bit lasts BIT_CLKS clocks, line idles high.
`default_nettype none
module urx_node #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clk_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_o = 1'h1;
    // Level held for n clocks, changed just after an edge
    task automatic hold(input logic v, input int n);
        @(posedge clk_i);
        line_o <= v;
        repeat (n - 1) @(posedge clk_i);
    endtask
    // ninth bit marks address bytes; noisy flips bit 0 near its centre
    task automatic send(input logic [7:0] d, input logic nine, input logic n9,
        input logic stp, input logic noisy);
        hold(1'h0, BIT_CLKS);
        for (int i = 0; i < 8; i++) begin
            if (i == 0 && noisy) begin
                hold(d[0], 15);
                hold(~d[0], 2);
                hold(d[0], BIT_CLKS - 17);
            end else begin
                hold(d[i], BIT_CLKS);
            end
        end
        if (nine) hold(n9, BIT_CLKS);
        hold(stp, BIT_CLKS);
        hold(1'h1, BIT_CLKS);
    endtask
    // Short dip that ends before the centre of a bit
    task automatic dip();
        hold(1'h0, 6);
        hold(1'h1, 2 * BIT_CLKS);
    endtask
endmodule
`default_nettype wire

// ===== uart_rx_addr_recognition_bench.sv
// Self-checking bench for the receive block with address recognition.
// Assumes the design files, the checker and the serial node model alongside.
`default_nettype none
`include "urx_consts.vh"
module uart_rx_addr_recognition_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, rd_d = 1'h0, ok;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, dat, b, c;
    logic [7:0] tbl [6] = '{8'hC0, 8'hC2, 8'hC1, 8'hFF, 8'hFD, 8'h40};
    wire [7:0] rdata_o;
    wire rxd, done_w, fe_w;
    int error_cnt = 0, samples_checked = 0;
    logic [19:0] exp_q [$];
    logic [19:0] e;
    always #5 clk_i = ~clk_i;
    urx_core dut (.clk_i(clk_i), .rst_i(rst_i), .rxd_i(rxd), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rx_done_flag_o(done_w), .framing_error_flag_o(fe_w));
    urx_node #(.BIT_CLKS(32)) node (.clk_i(clk_i), .line_o(rxd));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask
    // Read strobe; the expected value and the bits that matter go on the queue
    task automatic rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        exp_q.push_back({a, x, m});
        @(posedge clk_i);
        rd_i <= 1'h0;
    endtask
    task automatic chk(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m);
        samples_checked++;
        if ((rdata_o & m) !== (x & m)) begin
            error_cnt++;
            $display("[ERR] reg %0d expected %h seen %h", a, x & m, rdata_o & m);
        end
    endtask
    // Read data stand one cycle after the strobe; looked at mid-cycle
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            chk(e[19:16], e[15:8], e[7:0]);
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Whole run is near 7300 clocks; far beyond that counts as a hang
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
    initial begin
        dat = 8'($urandom(32'h09766951));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 6; i++) rd(i[3:0], 8'h00, 8'hFF);
        wr(4'hC, 8'hA5);
        rd(4'hC, 8'h00, 8'hFF);
        wr(`URX_OFF_BAUD, 8'h01);
        // Mode 1 with a noisy sample; a second frame is lost while done is set
        wr(`URX_OFF_CTRL, 8'h50);
        dat = 8'($urandom);
        node.send(dat, 1'h0, 1'h0, 1'h1, 1'h1);
        rd(`URX_OFF_BUF, dat, 8'hFF);
        rd(`URX_OFF_CTRL, 8'h55, 8'hF5);
        node.send(~dat, 1'h0, 1'h0, 1'h1, 1'h0);
        rd(`URX_OFF_BUF, dat, 8'hFF);
        wr(`URX_OFF_CTRL, 8'h50);
        node.dip();
        rd(`URX_OFF_CTRL, 8'h50, 8'hF1);
        // mode set before the error view; bad stop loads, then is lost with filter
        wr(`URX_OFF_PWR, 8'h40);
        node.send(8'h3C, 1'h0, 1'h0, 1'h0, 1'h0);
        rd(`URX_OFF_CTRL, 8'hD1, 8'hF5);
        rd(`URX_OFF_BUF, 8'h3C, 8'hFF);
        wr(`URX_OFF_CTRL, 8'hF0);
        node.send(8'h5A, 1'h0, 1'h0, 1'h0, 1'h0);
        rd(`URX_OFF_BUF, 8'h3C, 8'hFF);
        node.send(8'h5B, 1'h0, 1'h0, 1'h1, 1'h0);
        rd(`URX_OFF_CTRL, 8'hF5, 8'hF5);
        wr(`URX_OFF_CTRL, 8'h50);
        rd(`URX_OFF_CTRL, 8'h50, 8'hF1);
        wr(`URX_OFF_PWR, 8'h00);
        // Shift-register mode and disabled receiver take nothing
        for (int i = 0; i < 2; i++) begin
            c = i ? 8'h10 : 8'h40;
            wr(`URX_OFF_CTRL, c);
            node.send(dat, 1'h0, 1'h0, 1'h1, 1'h0);
            rd(`URX_OFF_CTRL, c, 8'hF1);
        end
        // Nine-bit modes without filter
        for (int m = 0; m < 2; m++) begin
            c = m ? 8'hD0 : 8'h90;
            dat = 8'($urandom);
            wr(`URX_OFF_CTRL, c);
            node.send(dat, 1'h1, m[0], 1'h1, 1'h0);
            rd(`URX_OFF_BUF, dat, 8'hFF);
            rd(`URX_OFF_CTRL, c | {5'h00, m[0], 2'h1}, 8'hF5);
        end
        // Filter with cleared address and mask: data dropped, any address taken
        wr(`URX_OFF_CTRL, 8'hF0);
        node.send(8'h11, 1'h1, 1'h0, 1'h1, 1'h0);
        rd(`URX_OFF_CTRL, 8'hF0, 8'hF5);
        node.send(8'h77, 1'h1, 1'h1, 1'h1, 1'h0);
        rd(`URX_OFF_BUF, 8'h77, 8'hFF);
        // Given and broadcast matching, expectation built from address and mask
        wr(`URX_OFF_ADDR, 8'hC0);
        wr(`URX_OFF_MASK, 8'hFD);
        for (int i = 0; i < 7; i++) begin
            b = (i < 6) ? tbl[i] : 8'($urandom);
            ok = ((b & 8'hFD) == 8'hC0) || ((b & 8'hFD) == 8'hFD);
            wr(`URX_OFF_CTRL, 8'hB0);
            node.send(b, 1'h1, 1'h1, 1'h1, 1'h0);
            rd(`URX_OFF_CTRL, 8'hB0 | {7'h00, ok}, 8'hF1);
        end
        // Addressed slave drops the filter and takes a data byte
        wr(`URX_OFF_CTRL, 8'h90);
        node.send(8'h6E, 1'h1, 1'h0, 1'h1, 1'h0);
        rd(`URX_OFF_BUF, 8'h6E, 8'hFF);
        repeat (4) @(posedge clk_i);
        test_done();
    end
endmodule
`default_nettype wire
